/* File: rtl/ufp_regs.svh */
// Register offsets, field positions, reset values and timing for the frame-format UART.
// Assumes an 8-bit byte address on the register port with word-aligned registers.
`ifndef UFP_REGS_SVH
`define UFP_REGS_SVH

`define UFP_CTRL_OFS 8'h00
`define UFP_TXDATA_OFS 8'h04
`define UFP_RXDATA_OFS 8'h08
`define UFP_RXERR_OFS 8'h0C
`define UFP_IRQ_STATUS_OFS 8'h10
`define UFP_IRQ_CLEAR_OFS 8'h14
`define UFP_IRQ_ENABLE_OFS 8'h18
`define UFP_STATE_OFS 8'h1C

`define UFP_ROUTE_BIT 0
`define UFP_STOP_BIT 1
`define UFP_LEN_BIT 2
`define UFP_PM_LO 3
`define UFP_PM_HI 4
`define UFP_RXEN_BIT 6
`define UFP_TXEN_BIT 7
`define UFP_CTRL_RESET 8'h00

`define UFP_PM_NONE 2'h0
`define UFP_PM_ZERO 2'h1
`define UFP_PM_ODD 2'h2
`define UFP_PM_EVEN 2'h3

`define UFP_IRQ_TXDONE 0
`define UFP_IRQ_RXDONE 1
`define UFP_IRQ_RXERR 2

`define UFP_ERR_PAR 2
`define UFP_ERR_FRM 1
`define UFP_ERR_OVR 0

`define UFP_CLKS_PER_BIT 16

`endif

/* File: rtl/ufp_pkg.sv */
// Types shared by the frame-format UART.
// Assumes nothing beyond a SystemVerilog compiler.
package ufp_pkg;

    typedef enum logic [2:0] {UFP_IDLE, UFP_START, UFP_DATA, UFP_PAR, UFP_STOP} ufp_phase_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] irq_st;
        logic [2:0] irq_en;
        logic irq;
        logic [31:0] rd_data;
        ufp_phase_t tx_st;
        logic [15:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic [1:0] tx_pm;
        logic tx_len8;
        logic tx_stop_n;
        logic txd;
        ufp_phase_t rx_st;
        logic [15:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic [1:0] rx_pm;
        logic rx_len8;
        logic [7:0] rx_data;
        logic rx_full;
        logic [2:0] err;
        logic fin;
        logic done_p;
        logic err_p;
    } ufp_state_t;

endpackage

/* File: rtl/ufp_uart.sv */
// Frame-format UART: parity, character length, stop length and error interrupt routing.
// Assumes a synchronous register master and a serial line already synchronous to ref_clk.
//
// Functional notes
// RULE_01 - Even mode: tx parity makes ones even.
// RULE_02 - Even mode: odd ones received flags error.
// RULE_03 - Odd mode: tx parity makes ones odd.
// RULE_04 - Zero mode: tx parity bit always 0.
// RULE_05 - Zero mode: receiver never flags parity error.
// RULE_06 - No-parity mode: tx frame has no parity.
// RULE_07 - No-parity mode: rx expects none, no error.
// RULE_08 - Length select: 0 gives 7, 1 gives 8.
// RULE_09 - Software disables tx, rx before length change.
// RULE_10 - Stop select: 0 one stop, 1 two.
// RULE_11 - Software disables tx before stop change.
// RULE_12 - Receiver always checks a single stop bit.
// RULE_13 - Route 0: error interrupt, no completion interrupt.
// RULE_14 - Route 1: completion interrupt, no error interrupt.
// RULE_15 - Odd mode: even ones received flags error.
// RULE_16 - Parity bit follows last data, precedes stop.
`timescale 1ns/100ps
`default_nettype none
`include "ufp_regs.svh"

module ufp_uart
    import ufp_pkg::*;
#(
    parameter int CLKS_PER_BIT = `UFP_CLKS_PER_BIT
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Serial line.
    input wire logic rxd,
    output logic txd,
    // Interrupts.
    output logic irq,
    output logic rx_complete_irq,
    output logic rx_error_irq
);

    localparam logic [15:0] BIT_LAST = 16'(CLKS_PER_BIT - 1);
    localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2 - 1);

    ufp_state_t s_r;
    ufp_state_t s_nxt;

    // Parity bit for a character in the given mode; zero and none give 0.
    function automatic logic par_of(input logic [7:0] d, input logic len8, input logic [1:0] pm);
        logic [7:0] m;
        m = len8 ? d : {1'h0, d[6:0]};
        case (pm)
            `UFP_PM_EVEN: par_of = ^m;
            `UFP_PM_ODD: par_of = ~^m;
            default: par_of = 1'h0;
        endcase
    endfunction

    // Next-state logic for the register port, transmitter and receiver.
    always_comb begin
        logic pe;
        logic [2:0] flags;
        pe = 1'h0;
        flags = 3'h0;
        s_nxt = s_r;
        s_nxt.rd_data = 32'h0000_0000;
        s_nxt.fin = 1'h0;
        s_nxt.done_p = 1'h0;
        s_nxt.err_p = 1'h0;

        // Register accesses; hardware sets below override these clears.
        if (wr_en) begin
            case (addr)
                `UFP_CTRL_OFS: s_nxt.ctrl = wr_data[7:0];
                `UFP_IRQ_CLEAR_OFS: s_nxt.irq_st = s_r.irq_st & ~wr_data[2:0];
                `UFP_IRQ_ENABLE_OFS: s_nxt.irq_en = wr_data[2:0];
                default: ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                `UFP_CTRL_OFS: s_nxt.rd_data = {24'h000000, s_r.ctrl};
                `UFP_RXDATA_OFS: begin
                    s_nxt.rd_data = {24'h000000, s_r.rx_data};
                    s_nxt.rx_full = 1'h0;
                end
                `UFP_RXERR_OFS: begin
                    s_nxt.rd_data = {29'h0, s_r.err};
                    s_nxt.err = 3'h0;
                end
                `UFP_IRQ_STATUS_OFS: s_nxt.rd_data = {29'h0, s_r.irq_st};
                `UFP_IRQ_ENABLE_OFS: s_nxt.rd_data = {29'h0, s_r.irq_en};
                `UFP_STATE_OFS: s_nxt.rd_data = {29'h0, s_r.rx_full,
                    s_r.rx_st != UFP_IDLE, s_r.tx_st != UFP_IDLE};
                default: s_nxt.rd_data = 32'h0000_0000;
            endcase
        end

        // Transmitter: start, data, optional parity, one or two stop bits.
        s_nxt.tx_cnt = s_r.tx_cnt + 16'h0001;
        case (s_r.tx_st)
            UFP_IDLE: begin
                s_nxt.txd = 1'h1;
                s_nxt.tx_cnt = 16'h0000;
                if (wr_en && addr == `UFP_TXDATA_OFS && s_r.ctrl[`UFP_TXEN_BIT]) begin
                    s_nxt.tx_sh = wr_data[7:0];
                    s_nxt.tx_pm = s_r.ctrl[`UFP_PM_HI:`UFP_PM_LO];
                    s_nxt.tx_len8 = s_r.ctrl[`UFP_LEN_BIT]; // [RULE_08]
                    s_nxt.tx_st = UFP_START;
                    s_nxt.txd = 1'h0;
                end
            end
            UFP_START: begin
                if (s_r.tx_cnt == BIT_LAST) begin
                    s_nxt.tx_cnt = 16'h0000;
                    s_nxt.tx_bit = 3'h0;
                    s_nxt.tx_st = UFP_DATA;
                    s_nxt.txd = s_r.tx_sh[0];
                end
            end
            UFP_DATA: begin
                if (s_r.tx_cnt == BIT_LAST) begin
                    s_nxt.tx_cnt = 16'h0000;
                    if (s_r.tx_bit == (s_r.tx_len8 ? 3'h7 : 3'h6)) begin // [RULE_08]
                        if (s_r.tx_pm != `UFP_PM_NONE) begin // [RULE_06] [RULE_16]
                            s_nxt.tx_st = UFP_PAR;
                            // Parity per mode. [RULE_01] [RULE_03] [RULE_04]
                            s_nxt.txd = par_of(s_r.tx_sh, s_r.tx_len8, s_r.tx_pm);
                        end else begin
                            s_nxt.tx_st = UFP_STOP;
                            s_nxt.txd = 1'h1;
                            s_nxt.tx_stop_n = s_r.ctrl[`UFP_STOP_BIT]; // [RULE_10]
                        end
                    end else begin
                        s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                        s_nxt.txd = s_r.tx_sh[s_r.tx_bit + 3'h1];
                    end
                end
            end
            UFP_PAR: begin
                if (s_r.tx_cnt == BIT_LAST) begin
                    s_nxt.tx_cnt = 16'h0000;
                    s_nxt.tx_st = UFP_STOP;
                    s_nxt.txd = 1'h1;
                    s_nxt.tx_stop_n = s_r.ctrl[`UFP_STOP_BIT]; // [RULE_10]
                end
            end
            UFP_STOP: begin
                if (s_r.tx_cnt == BIT_LAST) begin
                    s_nxt.tx_cnt = 16'h0000;
                    if (s_r.tx_stop_n) begin
                        s_nxt.tx_stop_n = 1'h0; // Second stop bit. [RULE_10]
                    end else begin
                        s_nxt.tx_st = UFP_IDLE;
                        s_nxt.irq_st[`UFP_IRQ_TXDONE] = 1'h1;
                    end
                end
            end
            default: s_nxt.tx_st = UFP_IDLE;
        endcase
        if (!s_r.ctrl[`UFP_TXEN_BIT]) begin
            s_nxt.tx_st = UFP_IDLE;
            s_nxt.txd = 1'h1;
        end

        // Receiver: mid-bit sampling, optional parity, always one stop bit.
        s_nxt.rx_cnt = s_r.rx_cnt + 16'h0001;
        case (s_r.rx_st)
            UFP_IDLE: begin
                s_nxt.rx_cnt = 16'h0000;
                if (s_r.ctrl[`UFP_RXEN_BIT] && !rxd) begin
                    s_nxt.rx_st = UFP_START;
                    s_nxt.rx_sh = 8'h00;
                    s_nxt.rx_pm = s_r.ctrl[`UFP_PM_HI:`UFP_PM_LO];
                    s_nxt.rx_len8 = s_r.ctrl[`UFP_LEN_BIT]; // [RULE_08]
                end
            end
            UFP_START: begin
                if (s_r.rx_cnt == HALF_LAST) begin
                    s_nxt.rx_cnt = 16'h0000;
                    s_nxt.rx_bit = 3'h0;
                    s_nxt.rx_st = rxd ? UFP_IDLE : UFP_DATA;
                end
            end
            UFP_DATA: begin
                if (s_r.rx_cnt == BIT_LAST) begin
                    s_nxt.rx_cnt = 16'h0000;
                    s_nxt.rx_sh[s_r.rx_bit] = rxd;
                    if (s_r.rx_bit == (s_r.rx_len8 ? 3'h7 : 3'h6)) begin // [RULE_08]
                        // A parity slot only when a parity mode is set. [RULE_07] [RULE_16]
                        s_nxt.rx_st = (s_r.rx_pm != `UFP_PM_NONE) ? UFP_PAR : UFP_STOP;
                    end else begin
                        s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                    end
                end
            end
            UFP_PAR: begin
                if (s_r.rx_cnt == BIT_LAST) begin
                    s_nxt.rx_cnt = 16'h0000;
                    s_nxt.rx_par = rxd;
                    s_nxt.rx_st = UFP_STOP;
                end
            end
            UFP_STOP: begin
                if (s_r.rx_cnt == BIT_LAST) begin
                    // One stop bit regardless of the stop select. [RULE_12]
                    s_nxt.rx_st = UFP_IDLE;
                    s_nxt.fin = 1'h1;
                    // Only odd and even modes judge parity. [RULE_02] [RULE_05] [RULE_07] [RULE_15]
                    if (s_r.rx_pm == `UFP_PM_EVEN || s_r.rx_pm == `UFP_PM_ODD) begin
                        pe = par_of(s_r.rx_sh, s_r.rx_len8, s_r.rx_pm) != s_r.rx_par;
                    end
                    flags = {pe, !rxd, s_r.rx_full};
                    s_nxt.err = flags;
                    if (!s_r.rx_full) begin
                        s_nxt.rx_data = s_r.rx_sh;
                        s_nxt.rx_full = 1'h1;
                    end
                    if (|flags && !s_r.ctrl[`UFP_ROUTE_BIT]) begin
                        s_nxt.irq_st[`UFP_IRQ_RXERR] = 1'h1; // [RULE_13]
                        s_nxt.err_p = 1'h1;
                    end else begin
                        s_nxt.irq_st[`UFP_IRQ_RXDONE] = 1'h1; // [RULE_14]
                        s_nxt.done_p = 1'h1;
                    end
                end
            end
            default: s_nxt.rx_st = UFP_IDLE;
        endcase
        if (!s_r.ctrl[`UFP_RXEN_BIT]) begin
            s_nxt.rx_st = UFP_IDLE;
            s_nxt.err = 3'h0;
        end

        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
    end

    // State register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= `UFP_CTRL_RESET;
            s_r.txd <= 1'h1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign rd_data = s_r.rd_data;
    assign txd = s_r.txd;
    assign irq = s_r.irq;
    assign rx_complete_irq = s_r.done_p;
    assign rx_error_irq = s_r.err_p;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    even_tx_par_a: assert property ( // [RULE_01]
        s_r.tx_st == UFP_PAR && s_r.tx_pm == `UFP_PM_EVEN |->
        s_r.txd == ^(s_r.tx_len8 ? s_r.tx_sh : {1'h0, s_r.tx_sh[6:0]}))
        else $error("Even parity bit wrong.");
    even_rx_check_a: assert property ( // [RULE_02]
        s_r.fin && s_r.rx_pm == `UFP_PM_EVEN |->
        s_r.err[`UFP_ERR_PAR] == ^{s_r.rx_data, s_r.rx_par} || s_r.err[`UFP_ERR_OVR])
        else $error("Even parity check wrong.");
    odd_tx_par_a: assert property ( // [RULE_03]
        s_r.tx_st == UFP_PAR && s_r.tx_pm == `UFP_PM_ODD |->
        s_r.txd == ~^(s_r.tx_len8 ? s_r.tx_sh : {1'h0, s_r.tx_sh[6:0]}))
        else $error("Odd parity bit wrong.");
    zero_tx_par_a: assert property ( // [RULE_04]
        s_r.tx_st == UFP_PAR && s_r.tx_pm == `UFP_PM_ZERO |-> !s_r.txd)
        else $error("Zero parity bit not low.");
    no_rx_perr_a: assert property ( // [RULE_05]
        s_r.fin && (s_r.rx_pm == `UFP_PM_ZERO || s_r.rx_pm == `UFP_PM_NONE)
        |-> !s_r.err[`UFP_ERR_PAR])
        else $error("Parity error without parity check.");
    no_par_slot_a: assert property ( // [RULE_06]
        s_r.tx_st == UFP_PAR |-> s_r.tx_pm != `UFP_PM_NONE)
        else $error("Parity slot sent in no-parity mode.");
    tx_len_bound_a: assert property ( // [RULE_08]
        s_r.tx_st == UFP_DATA |-> s_r.tx_bit <= (s_r.tx_len8 ? 3'h7 : 3'h6))
        else $error("Too many data bits.");
    stop_line_high_a: assert property ( // [RULE_10]
        $rose(s_r.tx_st == UFP_STOP) |-> s_r.txd [*8])
        else $error("Stop bit not high.");
    rx_one_stop_a: assert property ( // [RULE_12]
        s_r.rx_st == UFP_STOP && s_r.rx_cnt == BIT_LAST |=> s_r.rx_st == UFP_IDLE && s_r.fin)
        else $error("Receiver stop not single.");
    route_err_a: assert property ( // [RULE_13]
        s_r.fin && |s_r.err && !s_r.ctrl[`UFP_ROUTE_BIT] |-> s_r.err_p && !s_r.done_p)
        else $error("Error routing to error interrupt wrong.");
    route_done_a: assert property ( // [RULE_14]
        s_r.fin && s_r.ctrl[`UFP_ROUTE_BIT] |-> s_r.done_p && !s_r.err_p)
        else $error("Error routing to completion interrupt wrong.");
    odd_rx_check_a: assert property ( // [RULE_15]
        s_r.fin && s_r.rx_pm == `UFP_PM_ODD |->
        s_r.err[`UFP_ERR_PAR] == ~^{s_r.rx_data, s_r.rx_par} || s_r.err[`UFP_ERR_OVR])
        else $error("Odd parity check wrong.");
    par_after_data_a: assert property ( // [RULE_16]
        $rose(s_r.tx_st == UFP_PAR) |-> $past(s_r.tx_st) == UFP_DATA)
        else $error("Parity bit not after last data bit.");

endmodule

`default_nettype wire

/* File: dv/ufp_peer.sv */
// Remote serial peer: sends frames on the receive line and captures frames from txd.
// Assumes the line is idle high and both ends share the bit time CPB.
`timescale 1ns/100ps
`default_nettype none

module ufp_peer #(
    parameter int CPB = 8
) (
    // Clock.
    input wire logic ref_clk,
    // Serial lines seen from the remote end.
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;

    // Sends n levels, start first; the frame ends on one stop bit, so the line rests high.
    task automatic send(input logic [11:0] b, input int n);
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rxd <= b[i];
            repeat (CPB) @(posedge ref_clk);
        end
    endtask

    // Captures n levels at mid bit; a missing start leaves all ones so the compare fails.
    task automatic capture(input int n, output logic [11:0] b);
        int k;
        b = 12'hFFF;
        k = 0;
        while (txd !== 1'b0 && k < 64) begin
            @(posedge ref_clk);
            k++;
        end
        if (txd === 1'b0) begin
            repeat (CPB / 2) @(posedge ref_clk);
            for (int i = 0; i < n; i++) begin
                b[i] = txd;
                if (i < n - 1) repeat (CPB) @(posedge ref_clk);
            end
        end
    endtask
endmodule

`default_nettype wire

/* File: dv/uart_frame_format_parity_tb.sv */
// Self-checking bench for the frame-format UART: transmit and receive frames in every mode.
// Assumes the register map of ufp_regs.svh and a peer model on the serial lines.
`timescale 1ns/100ps
`default_nettype none
`include "ufp_regs.svh"

module uart_frame_format_parity_tb;
    localparam int CPB = 8;
    logic ref_clk, rst, wr_en, rd_en, rxd, txd, irq, rx_complete_irq, rx_error_irq;
    logic [7:0] addr, ctrl_now;
    logic [31:0] wr_data, rd_data;
    int mismatches = 0, check_count = 0, n_cmp = 0, n_err = 0;

    ufp_uart #(.CLKS_PER_BIT(CPB)) dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rxd(rxd),
        .txd(txd), .irq(irq), .rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq));
    ufp_peer #(.CPB(CPB)) peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

    // Clock of 4 ns.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Counts the receive interrupt pulses.
    always @(posedge ref_clk) begin
        if (rx_complete_irq === 1'b1) n_cmp++;
        if (rx_error_irq === 1'b1) n_err++;
    end

    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // Disables first, then sets the fields, then enables both directions.
    task automatic cfg(input logic [1:0] pm, input logic l8, input logic sl, input logic rt);
        wr(`UFP_CTRL_OFS, {24'h0, ctrl_now & 8'h3F});
        ctrl_now = {3'b000, pm, l8, sl, rt};
        wr(`UFP_CTRL_OFS, {24'h0, ctrl_now});
        ctrl_now = ctrl_now | 8'hC0;
        wr(`UFP_CTRL_OFS, {24'h0, ctrl_now});
    endtask

    // Builds the line levels of one frame with a single stop bit; flip spoils the parity.
    function automatic logic [11:0] frame(input logic [1:0] pm, input logic l8,
            input logic [7:0] d, input logic flip, output int n);
        logic [7:0] m;
        logic p;
        int k;
        m = l8 ? d : {1'b0, d[6:0]};
        p = (pm == `UFP_PM_EVEN) ? ^m : (pm == `UFP_PM_ODD) ? ~^m : 1'b0;
        frame = 12'hFFF;
        frame[0] = 1'b0;
        k = l8 ? 8 : 7;
        for (int i = 0; i < k; i++) frame[1 + i] = m[i];
        if (pm != `UFP_PM_NONE) begin
            frame[1 + k] = p ^ flip;
            k++;
        end
        n = k + 2;
    endfunction

    // Sends one character and checks the frame on txd and the stop length by the busy flag.
    task automatic tx_case(input logic [1:0] pm, input logic l8, input logic sl,
            input logic [7:0] d);
        logic [11:0] exp, got;
        logic [31:0] s;
        int n, k;
        cfg(pm, l8, sl, 1'b0);
        exp = frame(pm, l8, d, 1'b0, n);
        wr(`UFP_TXDATA_OFS, {24'h0, d});
        peer.capture(n, got);
        chk({20'h0, got}, {20'h0, exp});
        repeat (CPB - 1) @(posedge ref_clk);
        rd(`UFP_STATE_OFS, s);
        chk({31'h0, s[0]}, {31'h0, sl});
        k = 0;
        while (s[0] !== 1'b0 && k < 100) begin
            rd(`UFP_STATE_OFS, s);
            k++;
        end
        chk({31'h0, s[0]}, 32'h0);
    endtask

    // Receives one character and checks data, parity flag and which pulse fired.
    task automatic rx_case(input logic [1:0] pm, input logic l8, input logic rt,
            input logic [7:0] d, input logic flip);
        logic [11:0] f;
        logic [31:0] v;
        logic err;
        int n, c0, e0, k;
        cfg(pm, l8, 1'b1, rt);
        f = frame(pm, l8, d, flip, n);
        err = flip && (pm == `UFP_PM_ODD || pm == `UFP_PM_EVEN);
        c0 = n_cmp;
        e0 = n_err;
        peer.send(f, n);
        k = 0;
        while (n_cmp + n_err == c0 + e0 && k < 64) begin
            @(posedge ref_clk);
            k++;
        end
        chk(n_err - e0, {31'h0, err && !rt});
        chk(n_cmp - c0, {31'h0, !(err && !rt)});
        rd(`UFP_RXERR_OFS, v);
        chk({31'h0, v[`UFP_ERR_PAR]}, {31'h0, err});
        rd(`UFP_RXDATA_OFS, v);
        chk(v, {24'h0, l8 ? d : {1'b0, d[6:0]}});
    endtask

    // Masks, enables and clears the receive completion interrupt; reads an unmapped place.
    task automatic irq_case();
        logic [11:0] f;
        logic [31:0] v;
        int n;
        wr(`UFP_IRQ_CLEAR_OFS, 32'h7);
        wr(`UFP_IRQ_ENABLE_OFS, 32'h0);
        rd(`UFP_IRQ_STATUS_OFS, v);
        chk(v, 32'h0);
        // The receiver is still set to seven bits, no parity, from the last receive case.
        f = frame(`UFP_PM_NONE, 1'b0, 8'h11, 1'b0, n);
        peer.send(f, n);
        repeat (4) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        rd(`UFP_IRQ_STATUS_OFS, v);
        chk(v, 32'h2);
        wr(`UFP_IRQ_ENABLE_OFS, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        rd(`UFP_IRQ_ENABLE_OFS, v);
        chk(v, 32'h2);
        wr(`UFP_IRQ_CLEAR_OFS, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        rd(8'h20, v);
        chk(v, 32'h0);
    endtask

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        logic [31:0] v;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ctrl_now = 8'h00;
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`UFP_CTRL_OFS, v);
        chk(v, 32'h0);
        tx_case(`UFP_PM_EVEN, 1'b1, 1'b0, 8'hA7);
        tx_case(`UFP_PM_EVEN, 1'b1, 1'b1, 8'h3C);
        tx_case(`UFP_PM_ODD, 1'b1, 1'b0, 8'h3C);
        tx_case(`UFP_PM_ZERO, 1'b1, 1'b1, 8'h7F);
        tx_case(`UFP_PM_NONE, 1'b0, 1'b0, 8'hD5);
        tx_case(`UFP_PM_ODD, 1'b0, 1'b1, 8'h80);
        rx_case(`UFP_PM_EVEN, 1'b1, 1'b0, 8'h5A, 1'b0);
        rx_case(`UFP_PM_EVEN, 1'b1, 1'b0, 8'h5A, 1'b1);
        rx_case(`UFP_PM_ODD, 1'b0, 1'b1, 8'hC3, 1'b1);
        rx_case(`UFP_PM_ODD, 1'b1, 1'b0, 8'h01, 1'b0);
        rx_case(`UFP_PM_ZERO, 1'b1, 1'b0, 8'h0F, 1'b1);
        rx_case(`UFP_PM_NONE, 1'b0, 1'b0, 8'h7E, 1'b0);
        irq_case();
        print_verdict();
    end
endmodule

`default_nettype wire
